/* File: verilog/interval_timer_pkg.sv */
/*
 * constants shared by the prescaled interval timer: register offsets, field positions,
 * reset values and source encodings.
 * assumes a classic wishbone slave with 32-bit data, one register per aligned word.
 */
package interval_timer_pkg;
   // register indices; each register owns one aligned word, so its byte address on the
   // bus is four times its index
   localparam logic [7:0] IDX_MODE        = 8'h8B;
   localparam logic [7:0] IDX_FIRST_STAGE = 8'h8C;
   localparam logic [7:0] IDX_TIMER_STAGE = 8'h8D;
   localparam logic [7:0] IDX_SOURCE_SEL  = 8'h8E;
   localparam logic [7:0] IDX_IRQ_STATUS  = 8'h90;
   localparam logic [7:0] IDX_IRQ_MASK    = 8'h91;
   localparam logic [7:0] IDX_PIN_CTRL    = 8'h92;

   // reset values
   localparam logic [7:0] RST_MODE        = 8'h00;
   localparam logic [7:0] RST_STAGE       = 8'hFF;
   localparam logic [7:0] RST_SOURCE_SEL  = 8'h00;

   // mode register fields
   localparam int MODE_SEL_0_BIT   = 0;
   localparam int MODE_SEL_1_BIT   = 1;
   localparam int POLARITY_BIT     = 3;
   localparam int RUN_FLAG_BIT     = 4;
   localparam int MODE_SEL_2_BIT   = 6;

   // source select fields
   localparam int TX_SRC_LSB       = 0;
   localparam int TZ_SRC_LSB       = 4;
   localparam logic [7:0] SOURCE_SEL_MASK = 8'h33;

   // count source encodings
   localparam logic [1:0] SRC_DIV1 = 2'h0;
   localparam logic [1:0] SRC_DIV8 = 2'h1;
   localparam logic [1:0] SRC_RING = 2'h2;
   localparam logic [1:0] SRC_DIV2 = 2'h3;
   localparam logic [1:0] TZ_SRC_TX_UNDERFLOW = 2'h2;

   // interrupt status bits
   localparam int IRQ_TX_BIT   = 0;
   localparam int IRQ_EXT1_BIT = 1;

   // pin control register fields
   localparam int PIN_EXT1_EN_BIT = 0;
   localparam int PIN_SEL_BIT     = 1;

   localparam int DIV8_COUNT = 8;
   localparam int DIV2_COUNT = 2;
endpackage

/* File: verilog/count_clock_select.sv */
/*
 * count clock enables for timer x and timer z: divider pulses and a synchronised ring clock.
 * assumes ring_osc_i is asynchronous and much slower than clk_i.
 */
`timescale 1ns/1ps
module count_clock_select (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ring_osc_i,
   input  wire logic [1:0] tx_src_i,
   input  wire logic [1:0] tz_src_i,
   input  wire logic       tx_underflow_i,
   output logic            tx_tick_o,
   output logic            tz_tick_o
);
   logic [2:0] div_reg;
   logic       ring_s1_reg;
   logic       ring_s2_reg;
   logic       ring_s3_reg;
   logic       div2_tick;
   logic       div8_tick;
   logic       ring_tick;

   // free running divider; each wrap of its low bits is one slow tick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_reg <= 3'h0;
      end else begin
         div_reg <= div_reg + 3'h1;
      end
   end

   assign div2_tick = (div_reg[0] == 1'b1);
   assign div8_tick = (div_reg == 3'(interval_timer_pkg::DIV8_COUNT - 1));

   // ring clock passes two flops before the edge detector looks at it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ring_s1_reg <= 1'b0;
         ring_s2_reg <= 1'b0;
         ring_s3_reg <= 1'b0;
      end else begin
         ring_s1_reg <= ring_osc_i;
         ring_s2_reg <= ring_s1_reg;
         ring_s3_reg <= ring_s2_reg;
      end
   end

   assign ring_tick = ring_s2_reg & ~ring_s3_reg;

   // source multiplexers for both timers
   always_comb begin
      case (tx_src_i) // [R01]
         interval_timer_pkg::SRC_DIV1: tx_tick_o = 1'b1;
         interval_timer_pkg::SRC_DIV8: tx_tick_o = div8_tick;
         interval_timer_pkg::SRC_RING: tx_tick_o = ring_tick;
         default:                      tx_tick_o = div2_tick;
      endcase
      case (tz_src_i) // [R02]
         interval_timer_pkg::SRC_DIV1:            tz_tick_o = 1'b1;
         interval_timer_pkg::SRC_DIV8:            tz_tick_o = div8_tick;
         interval_timer_pkg::TZ_SRC_TX_UNDERFLOW: tz_tick_o = tx_underflow_i;
         default:                                 tz_tick_o = 1'b0;
      endcase
   end
endmodule // count_clock_select

/* File: verilog/prescaled_interval_timer.sv */
/*
 * timer x in timer mode: 8-bit prescaler and 8-bit timer stage with reload, wishbone
 * registers, sticky interrupt status with mask, external interrupt one edge detect.
 * assumes a classic wishbone master on clk_i and asynchronous pins synchronised here.
 */
// Implementation choice: the Wishbone register port.
// What this block does
// (R01) timer x count clock picked by two-bit source field: div1, div8, ring, div2
// (R02) timer z count clock field at bits 5..4: div1, div8, timer x underflow
// (R03) counter decrements, reloads on underflow and keeps counting by itself
// (R04) underflow rate is count clock divided by (n+1)(m+1)
// (R05) writing 1 to the run flag starts counting
// (R06) writing 0 to the run flag stops counting
// (R07) every timer stage underflow raises the timer x interrupt request
// (R08) counter pins act as general i/o or external interrupt one input
// (R09) reading the two stage registers returns the live counts
// (R10) write while stopped loads reload register and counter together
// (R11) write while running: reload next tick, counter second tick, resume third
// (R12) timer mode when mode bits 1..0 are 00 and bit 2 is 0
// (R13) polarity bit picks external interrupt edge: 0 rising, 1 falling
// (R14) prescaler counts each count clock, stage counts each prescaler underflow
// (R15) software writes zero to reserved source select bits 3 and 2
`timescale 1ns/1ps
module prescaled_interval_timer (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [9:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   output logic             irq_o,
   input  wire logic        ring_osc_i,
   input  wire logic        counter_pin_0_i,
   input  wire logic        counter_pin_1_i,
   output logic             tz_tick_o,
   output logic             tx_underflow_o
);
   typedef enum logic [1:0] {
      WR_IDLE   = 2'b00,
      WR_RELOAD = 2'b01,
      WR_COPY   = 2'b10,
      WR_RESUME = 2'b11
   } wr_state_t;

   logic [7:0]  mode_reg;
   logic [7:0]  source_sel_reg;
   logic [7:0]  first_stage_count;
   logic [7:0]  first_stage_reload;
   logic [7:0]  timer_stage_count;
   logic [7:0]  timer_stage_reload;
   logic [7:0]  pend_first_reg;
   logic [7:0]  pend_timer_reg;
   logic        pend_first_vld_reg;
   logic        pend_timer_vld_reg;
   logic [1:0]  irq_status_reg;
   logic [1:0]  irq_mask_reg;
   logic [1:0]  pin_ctrl_reg;
   wr_state_t   wr_state_reg;
   wr_state_t   wr_state_next;
   logic        pin0_s1_reg;
   logic        pin0_s2_reg;
   logic        pin1_s1_reg;
   logic        pin1_s2_reg;
   logic        ext_prev_reg;
   logic        tx_tick;
   logic        tz_tick;
   logic        timer_mode;
   logic        counting;
   logic        first_uf;
   logic        timer_uf;
   logic        access;
   logic        wr_lane0;
   logic        rd_status;
   logic        ext_level;
   logic        ext_edge;
   logic [7:0]  idx;
   logic [31:0] rd_data;

   // register index from word address; narrow registers sit in byte lane 0
   function automatic logic hit(input logic [7:0] a, input logic [7:0] i);
      return a == i;
   endfunction

   assign idx       = adr_i[9:2];
   assign access    = cyc_i & stb_i & ~ack_o;
   assign wr_lane0  = access & we_i & sel_i[0];
   assign rd_status = access & ~we_i & hit(idx, interval_timer_pkg::IDX_IRQ_STATUS);

   assign timer_mode = ~mode_reg[interval_timer_pkg::MODE_SEL_0_BIT]
                     & ~mode_reg[interval_timer_pkg::MODE_SEL_1_BIT]
                     & ~mode_reg[interval_timer_pkg::MODE_SEL_2_BIT]; // [R12]
   assign counting   = timer_mode & mode_reg[interval_timer_pkg::RUN_FLAG_BIT]
                     & ((wr_state_reg == WR_IDLE) | (wr_state_reg == WR_RESUME)); // [R11]

   count_clock_select u_clk_sel (
      .clk_i          (clk_i),
      .rst_i          (rst_i),
      .ring_osc_i     (ring_osc_i),
      .tx_src_i       (source_sel_reg[interval_timer_pkg::TX_SRC_LSB +: 2]),
      .tz_src_i       (source_sel_reg[interval_timer_pkg::TZ_SRC_LSB +: 2]),
      .tx_underflow_i (timer_uf),
      .tx_tick_o      (tx_tick),
      .tz_tick_o      (tz_tick)
   );

   // two cascaded down counters; the stage only moves on a prescaler underflow
   assign first_uf = counting & tx_tick & (first_stage_count == 8'h00); // [R14]
   assign timer_uf = first_uf & (timer_stage_count == 8'h00); // [R04]

   // a write while running is parked, then walks reload, copy and resume on count ticks
   always_comb begin
      wr_state_next = wr_state_reg;
      case (wr_state_reg)
         WR_IDLE: begin
            if (wr_lane0 & mode_reg[interval_timer_pkg::RUN_FLAG_BIT] & timer_mode
                & (hit(idx, interval_timer_pkg::IDX_FIRST_STAGE)
                 | hit(idx, interval_timer_pkg::IDX_TIMER_STAGE))) begin
               wr_state_next = WR_RELOAD;
            end
         end
         WR_RELOAD: if (tx_tick) wr_state_next = WR_COPY; // [R11]
         WR_COPY:   if (tx_tick) wr_state_next = WR_RESUME; // [R11]
         WR_RESUME: if (tx_tick) wr_state_next = WR_IDLE; // [R11]
         default:   wr_state_next = WR_IDLE;
      endcase
      if (~mode_reg[interval_timer_pkg::RUN_FLAG_BIT]) begin
         wr_state_next = WR_IDLE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_state_reg <= WR_IDLE;
      end else begin
         wr_state_reg <= wr_state_next;
      end
   end

   // parked write data; a second write to the same stage before the reload tick replaces the first
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_first_reg     <= interval_timer_pkg::RST_STAGE;
         pend_timer_reg     <= interval_timer_pkg::RST_STAGE;
         pend_first_vld_reg <= 1'b0;
         pend_timer_vld_reg <= 1'b0;
      end else begin
         if (wr_state_next == WR_IDLE) begin // a stop mid-transfer must not leave stale data
            pend_first_vld_reg <= 1'b0;
            pend_timer_vld_reg <= 1'b0;
         end
         if (wr_lane0 && wr_state_next == WR_RELOAD) begin
            if (hit(idx, interval_timer_pkg::IDX_FIRST_STAGE)) begin
               pend_first_reg     <= dat_i[7:0];
               pend_first_vld_reg <= 1'b1;
            end else begin
               pend_timer_reg     <= dat_i[7:0];
               pend_timer_vld_reg <= 1'b1;
            end
         end
      end
   end

   // reload registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         first_stage_reload <= interval_timer_pkg::RST_STAGE;
         timer_stage_reload <= interval_timer_pkg::RST_STAGE;
      end else if (wr_lane0 && !(mode_reg[interval_timer_pkg::RUN_FLAG_BIT] && timer_mode)) begin
         if (hit(idx, interval_timer_pkg::IDX_FIRST_STAGE)) begin
            first_stage_reload <= dat_i[7:0]; // [R10]
         end
         if (hit(idx, interval_timer_pkg::IDX_TIMER_STAGE)) begin
            timer_stage_reload <= dat_i[7:0]; // [R10]
         end
      end else if (wr_state_reg == WR_RELOAD && tx_tick) begin
         if (pend_first_vld_reg) first_stage_reload <= pend_first_reg; // [R11]
         if (pend_timer_vld_reg) timer_stage_reload <= pend_timer_reg; // [R11]
      end
   end

   // live counters: stopped writes land at once, running writes land on the copy tick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         first_stage_count <= interval_timer_pkg::RST_STAGE;
         timer_stage_count <= interval_timer_pkg::RST_STAGE;
      end else if (wr_lane0 && !(mode_reg[interval_timer_pkg::RUN_FLAG_BIT] && timer_mode)) begin
         if (hit(idx, interval_timer_pkg::IDX_FIRST_STAGE)) begin
            first_stage_count <= dat_i[7:0]; // [R10]
         end
         if (hit(idx, interval_timer_pkg::IDX_TIMER_STAGE)) begin
            timer_stage_count <= dat_i[7:0]; // [R10]
         end
      end else if (wr_state_reg == WR_COPY && tx_tick) begin
         if (pend_first_vld_reg) first_stage_count <= first_stage_reload; // [R11]
         if (pend_timer_vld_reg) timer_stage_count <= timer_stage_reload; // [R11]
      end else if (counting && tx_tick) begin
         if (first_uf) begin
            first_stage_count <= first_stage_reload; // [R03]
            if (timer_uf) begin
               timer_stage_count <= timer_stage_reload; // [R03]
            end else begin
               timer_stage_count <= timer_stage_count - 8'h01; // [R14]
            end
         end else begin
            first_stage_count <= first_stage_count - 8'h01; // [R14]
         end
      end
   end

   // mode, source select, interrupt mask and pin control registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_reg       <= interval_timer_pkg::RST_MODE;
         source_sel_reg <= interval_timer_pkg::RST_SOURCE_SEL;
         irq_mask_reg   <= 2'h0;
         pin_ctrl_reg   <= 2'h0;
      end else if (wr_lane0) begin
         if (hit(idx, interval_timer_pkg::IDX_MODE)) begin
            mode_reg <= dat_i[7:0]; // [R05] [R06]
         end
         if (hit(idx, interval_timer_pkg::IDX_SOURCE_SEL)) begin
            // reserved bits kept at zero so they read back as zero
            source_sel_reg <= dat_i[7:0] & interval_timer_pkg::SOURCE_SEL_MASK; // [R15]
         end
         if (hit(idx, interval_timer_pkg::IDX_IRQ_MASK)) begin
            irq_mask_reg <= dat_i[1:0];
         end
         if (hit(idx, interval_timer_pkg::IDX_PIN_CTRL)) begin
            pin_ctrl_reg <= dat_i[1:0];
         end
      end
   end

   // counter pins pass two flops; the selected one may serve as external interrupt one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin0_s1_reg <= 1'b0;
         pin0_s2_reg <= 1'b0;
         pin1_s1_reg <= 1'b0;
         pin1_s2_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
      end else begin
         pin0_s1_reg <= counter_pin_0_i;
         pin0_s2_reg <= pin0_s1_reg;
         pin1_s1_reg <= counter_pin_1_i;
         pin1_s2_reg <= pin1_s1_reg;
         ext_prev_reg <= ext_level;
      end
   end

   assign ext_level = pin_ctrl_reg[interval_timer_pkg::PIN_SEL_BIT] ? pin1_s2_reg
                                                                  : pin0_s2_reg; // [R08]
   assign ext_edge  = pin_ctrl_reg[interval_timer_pkg::PIN_EXT1_EN_BIT] & timer_mode
                    & (mode_reg[interval_timer_pkg::POLARITY_BIT]
                       ? (ext_prev_reg & ~ext_level)
                       : (~ext_prev_reg & ext_level)); // [R13]

   // sticky status, cleared by reading it; an event in the read cycle survives
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status_reg <= 2'h0;
      end else begin
         irq_status_reg[interval_timer_pkg::IRQ_TX_BIT] <= timer_uf
            | (irq_status_reg[interval_timer_pkg::IRQ_TX_BIT] & ~rd_status); // [R07]
         irq_status_reg[interval_timer_pkg::IRQ_EXT1_BIT] <= ext_edge
            | (irq_status_reg[interval_timer_pkg::IRQ_EXT1_BIT] & ~rd_status); // [R08]
      end
   end

   // read mux; stage registers show the live counts
   always_comb begin
      rd_data = 32'h0000_0000;
      case (idx)
         interval_timer_pkg::IDX_MODE:        rd_data[7:0] = mode_reg;
         interval_timer_pkg::IDX_FIRST_STAGE: rd_data[7:0] = first_stage_count; // [R09]
         interval_timer_pkg::IDX_TIMER_STAGE: rd_data[7:0] = timer_stage_count; // [R09]
         interval_timer_pkg::IDX_SOURCE_SEL:  rd_data[7:0] = source_sel_reg;
         interval_timer_pkg::IDX_IRQ_STATUS:  rd_data[1:0] = irq_status_reg;
         interval_timer_pkg::IDX_IRQ_MASK:    rd_data[1:0] = irq_mask_reg;
         interval_timer_pkg::IDX_PIN_CTRL:    rd_data[1:0] = pin_ctrl_reg;
         default:                             rd_data = 32'h0000_0000;
      endcase
   end

   // one-cycle answer after the request is seen; unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= access;
         dat_o <= access ? rd_data : 32'h0000_0000;
      end
   end

   // registered outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o          <= 1'b0;
         tz_tick_o      <= 1'b0;
         tx_underflow_o <= 1'b0;
      end else begin
         irq_o          <= |(irq_status_reg & irq_mask_reg);
         tz_tick_o      <= tz_tick; // [R02]
         tx_underflow_o <= timer_uf; // [R07]
      end
   end

   a_uf_sets_irq: assert property (@(posedge clk_i) disable iff (rst_i)
      timer_uf |=> irq_status_reg[interval_timer_pkg::IRQ_TX_BIT]) // [R07]
      else $error("underflow did not set status");
   a_reload_on_uf: assert property (@(posedge clk_i) disable iff (rst_i)
      (timer_uf && wr_state_reg == WR_IDLE)
      |=> timer_stage_count == $past(timer_stage_reload)) // [R03]
      else $error("stage not reloaded");
   a_stop_holds: assert property (@(posedge clk_i) disable iff (rst_i)
      (!mode_reg[interval_timer_pkg::RUN_FLAG_BIT] && !wr_lane0)
      |=> $stable(first_stage_count)) // [R06]
      else $error("counter moved while stopped");
   a_prescale_dec: assert property (@(posedge clk_i) disable iff (rst_i)
      (counting && tx_tick && first_stage_count != 8'h00 && !wr_lane0)
      |=> first_stage_count == $past(first_stage_count) - 8'h01) // [R14]
      else $error("prescaler did not decrement");
   a_stopped_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_lane0 && !mode_reg[interval_timer_pkg::RUN_FLAG_BIT]
       && hit(idx, interval_timer_pkg::IDX_TIMER_STAGE))
      |=> timer_stage_count == $past(dat_i[7:0])
          && timer_stage_reload == $past(dat_i[7:0])) // [R10]
      else $error("stopped write not applied to both");
   a_run_start: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_lane0 && hit(idx, interval_timer_pkg::IDX_MODE) && dat_i[7:0] == 8'h10)
      |=> counting) // [R05]
      else $error("run flag did not start counting");
   a_mode_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode_reg[interval_timer_pkg::MODE_SEL_2_BIT]) |-> !counting) // [R12]
      else $error("counting outside timer mode");
   a_busy_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_state_reg == WR_RELOAD) |-> !timer_uf) // [R11]
      else $error("counting during write transfer");
   a_live_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (access && !we_i && hit(idx, interval_timer_pkg::IDX_FIRST_STAGE))
      |=> dat_o[7:0] == $past(first_stage_count)) // [R09]
      else $error("prescaler read not live");
endmodule // prescaled_interval_timer

/* File: verif/tb.sv */
/*
 * self-checking bench for the prescaled interval timer: wishbone register tasks,
 * period measurement per count source, run/stop, reload transfer, interrupts, pins.
 * assumes the design's assertions sit in its own files; the bench drives every pin.
 */
`timescale 1ns/1ps
module tb;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ring_osc_i;
   logic        counter_pin_0_i, counter_pin_1_i;
   logic [9:0]  adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, dat_o, q, q2;
   logic        ack_o, irq_o, tz_tick_o, tx_underflow_o;
   logic [4:0]  ring_cnt;
   logic [1:0]  srcs [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
   int          divs [4] = '{1, 8, 40, 2};
   logic [1:0]  tzs  [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
   int          tzn  [4] = '{80, 10, 0, 8};
   int          n_mismatch, num_checks, gap, cnt;

   prescaled_interval_timer DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .irq_o(irq_o), .ring_osc_i(ring_osc_i), .counter_pin_0_i(counter_pin_0_i),
      .counter_pin_1_i(counter_pin_1_i), .tz_tick_o(tz_tick_o),
      .tx_underflow_o(tx_underflow_o));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // slow ring clock: one rising edge every 40 system cycles
   always @(posedge clk_i) begin
      if (ring_cnt == 5'd19) begin
         ring_cnt   <= 5'd0;
         ring_osc_i <= ~ring_osc_i;
      end else begin
         ring_cnt <= ring_cnt + 5'd1;
      end
   end

   task automatic results();
      if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic timeout();
      check("wait bound", 32'h1, 32'h0);
      results();
   endtask

   // one classic cycle; held until ack is sampled high at a rising edge
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     output logic [31:0] r);
      int k;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= {idx, 2'b00};
      dat_i <= {24'h000000, d};
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 50);
      r = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
      if (k >= 50) timeout();
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] r;
      wb(1'b1, idx, d, r);
   endtask

   task automatic rdc(input string what, input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] r;
      wb(1'b0, idx, 8'h00, r);
      check(what, r, {24'h000000, exp});
   endtask

   // cycles between two consecutive underflow pulses
   task automatic measure(output int g);
      int k;
      k = 0;
      while (tx_underflow_o !== 1'b1) begin
         @(negedge clk_i);
         k++;
         if (k > 2000) timeout();
      end
      g = 0;
      do begin
         @(negedge clk_i);
         g++;
      end while (tx_underflow_o !== 1'b1 && g < 2000);
      if (g >= 2000) timeout();
   endtask

   task automatic pin(input logic p1, input logic v, input logic [7:0] exp);
      @(posedge clk_i);
      if (p1) counter_pin_1_i <= v;
      else counter_pin_0_i <= v;
      repeat (6) @(posedge clk_i);
      rdc("ext status", interval_timer_pkg::IDX_IRQ_STATUS, exp);
   endtask

   initial begin
      {rst_i, cyc_i, stb_i, we_i, ring_osc_i, counter_pin_0_i, counter_pin_1_i} = 7'h40;
      {adr_i, sel_i, dat_i, ring_cnt} = '0;
      sel_i = 4'hF;
      n_mismatch = 0;
      num_checks = 0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rdc("mode", interval_timer_pkg::IDX_MODE, interval_timer_pkg::RST_MODE);
      rdc("first", interval_timer_pkg::IDX_FIRST_STAGE, interval_timer_pkg::RST_STAGE);
      rdc("stage", interval_timer_pkg::IDX_TIMER_STAGE, interval_timer_pkg::RST_STAGE);
      rdc("src", interval_timer_pkg::IDX_SOURCE_SEL, interval_timer_pkg::RST_SOURCE_SEL);
      rdc("unmapped", 8'h00, 8'h00);
      wr(interval_timer_pkg::IDX_SOURCE_SEL, 8'hF3);
      rdc("src bits", interval_timer_pkg::IDX_SOURCE_SEL, 8'h33);
      // stopped writes land in counter and reload at once
      wr(interval_timer_pkg::IDX_FIRST_STAGE, 8'h03);
      wr(interval_timer_pkg::IDX_TIMER_STAGE, 8'h04);
      rdc("first wr", interval_timer_pkg::IDX_FIRST_STAGE, 8'h03);
      rdc("stage wr", interval_timer_pkg::IDX_TIMER_STAGE, 8'h04);
      // second gap after start is clean; (3+1)(4+1) ticks per period
      for (int i = 0; i < 4; i++) begin
         wr(interval_timer_pkg::IDX_SOURCE_SEL, {6'h00, srcs[i]});
         wr(interval_timer_pkg::IDX_MODE, 8'h10);
         measure(gap);
         measure(gap);
         check("period", 32'(gap), 32'(20 * divs[i]));
         wr(interval_timer_pkg::IDX_MODE, 8'h00);
      end
      wb(1'b0, interval_timer_pkg::IDX_TIMER_STAGE, 8'h00, q);
      repeat (30) @(posedge clk_i);
      wb(1'b0, interval_timer_pkg::IDX_TIMER_STAGE, 8'h00, q2);
      check("stopped", q2, q);
      // op mode bit 2 set leaves timer mode: the run flag alone must not count
      wr(interval_timer_pkg::IDX_MODE, 8'h50);
      repeat (30) @(posedge clk_i);
      wb(1'b0, interval_timer_pkg::IDX_TIMER_STAGE, 8'h00, q);
      check("not timer mode", q, q2);
      check("irq masked", 32'(irq_o), 32'h0);
      rdc("status", interval_timer_pkg::IDX_IRQ_STATUS, 8'h01);
      rdc("status clr", interval_timer_pkg::IDX_IRQ_STATUS, 8'h00);
      wr(interval_timer_pkg::IDX_SOURCE_SEL, 8'h00);
      wr(interval_timer_pkg::IDX_IRQ_MASK, 8'h01);
      wr(interval_timer_pkg::IDX_MODE, 8'h10);
      measure(gap);
      repeat (3) @(negedge clk_i);
      check("irq on", 32'(irq_o), 32'h1);
      // running write: transfer over three ticks, then (1+1)(4+1)
      wr(interval_timer_pkg::IDX_FIRST_STAGE, 8'h01);
      measure(gap);
      measure(gap);
      check("new period", 32'(gap), 32'd10);
      // timer z tick count over 80 cycles, timer x period 10
      for (int i = 0; i < 4; i++) begin
         wr(interval_timer_pkg::IDX_SOURCE_SEL, {2'h0, tzs[i], 4'h0});
         cnt = 0;
         repeat (80) begin
            @(negedge clk_i);
            if (tz_tick_o === 1'b1) cnt++;
         end
         check("tz ticks", 32'(cnt), 32'(tzn[i]));
      end
      wr(interval_timer_pkg::IDX_MODE, 8'h00);
      wb(1'b0, interval_timer_pkg::IDX_IRQ_STATUS, 8'h00, q);
      repeat (3) @(negedge clk_i);
      check("irq off", 32'(irq_o), 32'h0);
      // external interrupt one: rising, then falling polarity, then pin 1
      wr(interval_timer_pkg::IDX_PIN_CTRL, 8'h01);
      wr(interval_timer_pkg::IDX_IRQ_MASK, 8'h02);
      pin(1'b0, 1'b1, 8'h02);
      wr(interval_timer_pkg::IDX_MODE, 8'h08);
      wb(1'b0, interval_timer_pkg::IDX_IRQ_STATUS, 8'h00, q);
      pin(1'b0, 1'b0, 8'h02);
      pin(1'b0, 1'b1, 8'h00);
      wr(interval_timer_pkg::IDX_PIN_CTRL, 8'h03);
      // moving to the other pin can look like an edge; clear it before testing
      wb(1'b0, interval_timer_pkg::IDX_IRQ_STATUS, 8'h00, q);
      pin(1'b1, 1'b1, 8'h00);
      pin(1'b1, 1'b0, 8'h02);
      results();
   end
endmodule // tb
